/* design/smc_top.sv */
// Strobed register access was decided locally.
`timescale 1ns/1ps
module smc_top (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic ccp_io_key_wr,
	input wire logic cpu_instr_done,
	input wire logic sleep_instr,
	input wire logic debug_break,
	input wire logic irq_pin,
	input wire logic irq_bod_vlm,
	input wire logic irq_rtc,
	input wire logic irq_pit,
	input wire logic irq_twi_addr,
	input wire logic irq_ccl,
	input wire logic irq_usart_sof,
	input wire logic irq_other,
	input wire logic rtc_run_in_standby,
	input wire logic ccl_run_in_standby,
	input wire logic [1:0] lut_filter_select,
	input wire logic lut_edge_detect,
	input wire logic stby_keep_main_clk,
	input wire logic lowfreq_users,
	input wire logic osc_ready,
	input wire logic vreg_ready,
	input wire logic bod_wait_fuse,
	input wire logic bod_ready,
	output logic cpu_sleeping,
	output logic cpu_resume,
	output logic main_clk_en,
	output logic internal_32k_oscillator_en,
	output logic vreg_low_power
);
	smc_wake_if wk ();

	smc_wake_timer u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wk(wk.tmr)
	);

	// register file state
	logic [2:0] sleep_mode_select_q, sleep_mode_select_d;
	logic sen_q, sen_d;
	logic htll_q, htll_d;
	logic [2:0] regulator_power_mode_q, regulator_power_mode_d;
	logic [2:0] ccp_cnt_q, ccp_cnt_d;
	logic [7:0] rdata_q, rdata_d;
	logic ctrl_wr, vreg_wr, vreg_ok;

	assign ctrl_wr = reg_wr && (reg_addr == smc_pkg::SLEEP_CTRL_OFS);
	assign vreg_wr = reg_wr && (reg_addr == smc_pkg::VREG_CTRL_OFS);
	assign vreg_ok = vreg_wr && (ccp_cnt_q != 3'h0);

	always_comb
	begin
		sleep_mode_select_d = sleep_mode_select_q;
		sen_d = sen_q;
		htll_d = htll_q;
		regulator_power_mode_d = regulator_power_mode_q;
		ccp_cnt_d = ccp_cnt_q;
		rdata_d = 8'h00;
		if (ctrl_wr)
		begin
			sleep_mode_select_d = reg_wdata[smc_pkg::SLEEP_MODE_SELECT_MSB:smc_pkg::SLEEP_MODE_SELECT_LSB];
			sen_d = reg_wdata[smc_pkg::SEN_BIT];
		end
		// without an open key window the write is dropped silently
		if (vreg_ok)
		begin
			htll_d = reg_wdata[smc_pkg::HTLL_BIT];
			regulator_power_mode_d = reg_wdata[smc_pkg::REGULATOR_POWER_MODE_MSB:smc_pkg::REGULATOR_POWER_MODE_LSB];
		end
		// a fresh key beats both the consuming write and the countdown
		if (ccp_io_key_wr)
			ccp_cnt_d = smc_pkg::CCP_WINDOW;
		else if (vreg_ok)
			ccp_cnt_d = 3'h0;
		else if (cpu_instr_done && ccp_cnt_q != 3'h0)
			ccp_cnt_d = ccp_cnt_q - 3'h1;
		if (reg_rd)
		begin
			if (reg_addr == smc_pkg::SLEEP_CTRL_OFS)
				rdata_d = {4'h0, sleep_mode_select_q, sen_q};
			else if (reg_addr == smc_pkg::VREG_CTRL_OFS)
				rdata_d = {3'h0, htll_q, 1'b0, regulator_power_mode_q};
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			{sleep_mode_select_q, sen_q} <= smc_pkg::SLEEP_CTRL_RST;
			{htll_q, regulator_power_mode_q} <= smc_pkg::VREG_CTRL_RST;
			ccp_cnt_q <= 3'h0;
			rdata_q <= 8'h00;
		end
		else
		begin
			sleep_mode_select_q <= sleep_mode_select_d;
			sen_q <= sen_d;
			htll_q <= htll_d;
			regulator_power_mode_q <= regulator_power_mode_d;
			ccp_cnt_q <= ccp_cnt_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// sleep sequencing state
	smc_pkg::smc_state_t st_q, st_d;
	logic [2:0] mode_q, mode_d;
	logic clk_off_q, clk_off_d;
	logic need_q, need_d;
	logic main_clk_q, main_clk_d;
	logic internal_32k_oscillator_q, internal_32k_oscillator_d;
	logic vreg_low_q, vreg_low_d;
	logic resume_q, resume_d;
	logic mode_valid, enter, lut_async, src_ok, wake_req;

	assign mode_valid = (sleep_mode_select_q == smc_pkg::SLEEP_MODE_SELECT_IDLE) || (sleep_mode_select_q == smc_pkg::SLEEP_MODE_SELECT_STANDBY)
		|| (sleep_mode_select_q == smc_pkg::SLEEP_MODE_SELECT_POWER_DOWN_CODE);
	// reserved mode codes make the sleep instruction a no-op
	assign enter = sleep_instr && sen_q && mode_valid;
	assign lut_async = (lut_filter_select == smc_pkg::LUT_FILT_ASYNC)
		&& (lut_edge_detect == smc_pkg::LUT_EDGE_OFF);

	always_comb
	begin
		src_ok = 1'b0;
		case (mode_q)
			smc_pkg::SLEEP_MODE_SELECT_IDLE:
				src_ok = irq_pin | irq_bod_vlm | irq_rtc | irq_pit | irq_twi_addr
					| irq_ccl | irq_usart_sof | irq_other;
			smc_pkg::SLEEP_MODE_SELECT_STANDBY:
				src_ok = irq_pin | irq_bod_vlm | (irq_rtc & rtc_run_in_standby) | irq_pit
					| irq_twi_addr | (irq_ccl & ccl_run_in_standby) | irq_usart_sof;
			smc_pkg::SLEEP_MODE_SELECT_POWER_DOWN_CODE:
				// counter interrupts other than the periodic one are not listened to
				src_ok = irq_pin | irq_bod_vlm | (irq_pit & ~htll_q)
					| (irq_twi_addr & ~htll_q) | (irq_ccl & lut_async);
			default:
				src_ok = 1'b0;
		endcase
	end

	assign wake_req = src_ok || debug_break;

	always_comb
	begin
		st_d = st_q;
		mode_d = mode_q;
		clk_off_d = clk_off_q;
		need_d = need_q;
		resume_d = 1'b0;
		case (st_q)
			smc_pkg::SMC_ACTIVE:
				if (enter)
				begin
					st_d = smc_pkg::SMC_SLEEP;
					mode_d = sleep_mode_select_q;
					// idle keeps the main clock; standby only when a peripheral asks
					clk_off_d = (sleep_mode_select_q == smc_pkg::SLEEP_MODE_SELECT_POWER_DOWN_CODE)
						|| (sleep_mode_select_q == smc_pkg::SLEEP_MODE_SELECT_STANDBY && !stby_keep_main_clk);
					need_d = (sleep_mode_select_q != smc_pkg::SLEEP_MODE_SELECT_IDLE)
						&& (sleep_mode_select_q == smc_pkg::SLEEP_MODE_SELECT_POWER_DOWN_CODE || !stby_keep_main_clk
						|| regulator_power_mode_q == smc_pkg::REGULATOR_POWER_MODE_AUTO);
				end
			smc_pkg::SMC_SLEEP:
				if (wake_req)
					st_d = smc_pkg::SMC_WAKE;
			smc_pkg::SMC_WAKE:
				if (wk.done)
				begin
					// settings registers untouched so the next sleep reuses them
					st_d = smc_pkg::SMC_ACTIVE;
					resume_d = 1'b1;
				end
			default:
				st_d = smc_pkg::SMC_ACTIVE;
		endcase
		main_clk_d = !(st_d == smc_pkg::SMC_SLEEP && clk_off_d);
		internal_32k_oscillator_d = !(st_d == smc_pkg::SMC_SLEEP && mode_d == smc_pkg::SLEEP_MODE_SELECT_POWER_DOWN_CODE)
			|| lowfreq_users;
		vreg_low_d = (st_d == smc_pkg::SMC_SLEEP) && (mode_d != smc_pkg::SLEEP_MODE_SELECT_IDLE)
			&& (regulator_power_mode_q == smc_pkg::REGULATOR_POWER_MODE_AUTO);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st_q <= smc_pkg::SMC_ACTIVE;
			mode_q <= smc_pkg::SLEEP_MODE_SELECT_IDLE;
			clk_off_q <= 1'b0;
			need_q <= 1'b0;
			main_clk_q <= 1'b1;
			internal_32k_oscillator_q <= 1'b1;
			vreg_low_q <= 1'b0;
			resume_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			mode_q <= mode_d;
			clk_off_q <= clk_off_d;
			need_q <= need_d;
			main_clk_q <= main_clk_d;
			internal_32k_oscillator_q <= internal_32k_oscillator_d;
			vreg_low_q <= vreg_low_d;
			resume_q <= resume_d;
		end
	end

	assign wk.start = (st_q == smc_pkg::SMC_SLEEP) && wake_req;
	assign wk.need_startup = need_q;
	assign wk.startup_ok = osc_ready && vreg_ready;
	assign wk.bod_ok = !bod_wait_fuse || bod_ready;

	assign cpu_sleeping = (st_q != smc_pkg::SMC_ACTIVE);
	assign cpu_resume = resume_q;
	assign main_clk_en = main_clk_q;
	assign internal_32k_oscillator_en = internal_32k_oscillator_q;
	assign vreg_low_power = vreg_low_q;

	chk_mode_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_ACTIVE && sleep_instr && sen_q && sleep_mode_select_q == 3'h2
		|=> st_q == smc_pkg::SMC_SLEEP && mode_q == 3'h2)
		else $error("power-down code did not enter power-down");
	chk_idle_clock: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_SLEEP && mode_q == smc_pkg::SLEEP_MODE_SELECT_IDLE |-> main_clk_en && !need_q)
		else $error("idle sleep stopped the main clock");
	chk_power_down_code_clocks: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_SLEEP && mode_q == smc_pkg::SLEEP_MODE_SELECT_POWER_DOWN_CODE
		|-> !main_clk_en && internal_32k_oscillator_en == $past(lowfreq_users))
		else $error("power-down clock gating wrong");
	chk_stby_clock: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_ACTIVE && enter && sleep_mode_select_q == smc_pkg::SLEEP_MODE_SELECT_STANDBY
		|=> main_clk_en == $past(stby_keep_main_clk))
		else $error("standby main clock ignores keep request");
	chk_debug_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_SLEEP && debug_break |-> wk.start ##1 st_q == smc_pkg::SMC_WAKE)
		else $error("debug break did not wake");
	chk_ccp_unlock: assert property (@(posedge core_clk) disable iff (!rst_n)
		ccp_io_key_wr ##1 vreg_wr |=> {htll_q, regulator_power_mode_q} == $past({reg_wdata[4], reg_wdata[2:0]}))
		else $error("keyed regulator write lost");
	chk_ccp_guard: assert property (@(posedge core_clk) disable iff (!rst_n)
		vreg_wr && ccp_cnt_q == 3'h0 && !ccp_io_key_wr |=> $stable({htll_q, regulator_power_mode_q}))
		else $error("unkeyed regulator write took effect");
	chk_htll_block: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_SLEEP && mode_q == smc_pkg::SLEEP_MODE_SELECT_POWER_DOWN_CODE && htll_q && !debug_break
		&& !irq_pin && !irq_bod_vlm && !irq_ccl |-> !wk.start)
		else $error("blocked source woke power-down");
	chk_ccl_async: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_SLEEP && mode_q == smc_pkg::SLEEP_MODE_SELECT_POWER_DOWN_CODE && irq_ccl
		|-> wk.start == (lut_async || src_ok && !irq_ccl || debug_break || irq_pin
		|| irq_bod_vlm || (irq_pit || irq_twi_addr) && !htll_q))
		else $error("logic wake gating wrong");
	chk_rtc_stby: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_SLEEP && mode_q == smc_pkg::SLEEP_MODE_SELECT_STANDBY && irq_rtc
		&& rtc_run_in_standby |-> wk.start)
		else $error("counter wake lost in standby");
	chk_idle_any: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_SLEEP && mode_q == smc_pkg::SLEEP_MODE_SELECT_IDLE && irq_other |-> wk.start)
		else $error("idle ignored an interrupt");
	chk_resume: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_WAKE && wk.done && !ctrl_wr
		|=> st_q == smc_pkg::SMC_ACTIVE && cpu_resume && $stable({sleep_mode_select_q, sen_q}))
		else $error("wake did not return to active");
	chk_vreg_low: assert property (@(posedge core_clk) disable iff (!rst_n)
		vreg_low_power |-> $past(regulator_power_mode_q) == smc_pkg::REGULATOR_POWER_MODE_AUTO)
		else $error("regulator low power outside auto mode");

	cov_idle_wake: cover property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_WAKE && mode_q == smc_pkg::SLEEP_MODE_SELECT_IDLE && wk.done);
	cov_power_down_code_wake: cover property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_WAKE && mode_q == smc_pkg::SLEEP_MODE_SELECT_POWER_DOWN_CODE && wk.done);
	cov_debug_wake: cover property (@(posedge core_clk) disable iff (!rst_n)
		st_q == smc_pkg::SMC_SLEEP && debug_break && !src_ok);
	cov_ccp_write: cover property (@(posedge core_clk) disable iff (!rst_n) vreg_ok);
endmodule

/* design/smc_pkg.sv */
package smc_pkg;
	localparam logic [7:0] SLEEP_CTRL_OFS = 8'h00;
	localparam logic [7:0] VREG_CTRL_OFS = 8'h01;
	localparam logic [3:0] SLEEP_CTRL_RST = 4'h0;
	localparam logic [3:0] VREG_CTRL_RST = 4'h0;
	localparam int SEN_BIT = 0;
	localparam int SLEEP_MODE_SELECT_LSB = 1;
	localparam int SLEEP_MODE_SELECT_MSB = 3;
	localparam int HTLL_BIT = 4;
	localparam int REGULATOR_POWER_MODE_LSB = 0;
	localparam int REGULATOR_POWER_MODE_MSB = 2;
	localparam logic [2:0] SLEEP_MODE_SELECT_IDLE = 3'h0;
	localparam logic [2:0] SLEEP_MODE_SELECT_STANDBY = 3'h1;
	localparam logic [2:0] SLEEP_MODE_SELECT_POWER_DOWN_CODE = 3'h2;
	localparam logic [2:0] REGULATOR_POWER_MODE_AUTO = 3'h0;
	localparam logic [2:0] REGULATOR_POWER_MODE_FULL = 3'h1;
	localparam logic [2:0] WAKE_CYCLES = 3'h6;
	localparam logic [2:0] CCP_WINDOW = 3'h4;
	localparam logic [1:0] LUT_FILT_ASYNC = 2'h0;
	localparam logic LUT_EDGE_OFF = 1'b0;
	typedef enum {SMC_ACTIVE, SMC_SLEEP, SMC_WAKE} smc_state_t;
	typedef enum {SMC_T_IDLE, SMC_T_STARTUP, SMC_T_COUNT} smc_tmr_state_t;
endpackage

/* design/smc_wake_if.sv */
`timescale 1ns/1ps
interface smc_wake_if;
	logic start;
	logic need_startup;
	logic startup_ok;
	logic bod_ok;
	logic done;
	modport ctl (output start, output need_startup, output startup_ok, output bod_ok, input done);
	modport tmr (input start, input need_startup, input startup_ok, input bod_ok, output done);
endinterface

/* design/smc_wake_timer.sv */
`timescale 1ns/1ps
module smc_wake_timer (
	input wire logic core_clk,
	input wire logic rst_n,
	smc_wake_if.tmr wk
);
	smc_pkg::smc_tmr_state_t st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic done_q, done_d;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		case (st_q)
			smc_pkg::SMC_T_IDLE:
				if (wk.start)
				begin
					cnt_d = 3'h0;
					st_d = wk.need_startup ? smc_pkg::SMC_T_STARTUP : smc_pkg::SMC_T_COUNT;
				end
			smc_pkg::SMC_T_STARTUP:
				if (wk.startup_ok)
					st_d = smc_pkg::SMC_T_COUNT;
			smc_pkg::SMC_T_COUNT:
				if (cnt_q != smc_pkg::WAKE_CYCLES)
					cnt_d = cnt_q + 3'h1;
				else if (wk.bod_ok)
				begin
					// brown-out wait only stretches past the six cycles, never adds to them
					done_d = 1'b1;
					st_d = smc_pkg::SMC_T_IDLE;
				end
			default:
				st_d = smc_pkg::SMC_T_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st_q <= smc_pkg::SMC_T_IDLE;
			cnt_q <= 3'h0;
			done_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	assign wk.done = done_q;

	chk_six_cycle_min: assert property (@(posedge core_clk) disable iff (!rst_n)
		wk.start |=> !wk.done [*7])
		else $error("wake finished before six cycles");
	chk_startup_first: assert property (@(posedge core_clk) disable iff (!rst_n)
		wk.start && wk.need_startup ##1 !wk.startup_ok |=> !wk.done [*7])
		else $error("wake ended without start-up plus six cycles");
	chk_bod_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		wk.done |-> $past(wk.bod_ok))
		else $error("wake ended while brown-out detector not ready");
	chk_idle_exact: assert property (@(posedge core_clk) disable iff (!rst_n)
		wk.start && !wk.need_startup ##1 wk.bod_ok [*7] |=> wk.done)
		else $error("clock-running wake not done in eight cycles");
endmodule

/* test/smc_cpu_model.sv */
`timescale 1ns/1ps
module smc_cpu_model #(
	parameter int OSC_DLY = 10,
	parameter int VREG_DLY = 5
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic cpu_sleeping,
	input wire logic main_clk_en,
	input wire logic vreg_low_power,
	output logic cpu_instr_done,
	output logic osc_ready,
	output logic vreg_ready
);
	int osc_cnt = 0;
	int vreg_cnt = 0;
	// a stopped source restarts its full start-up delay, never ready at once
	always @(posedge core_clk)
	begin
		cpu_instr_done <= rst_n && run && !cpu_sleeping;
		osc_cnt <= (!rst_n || !main_clk_en) ? 0 : osc_cnt + 1;
		vreg_cnt <= (!rst_n || vreg_low_power) ? 0 : vreg_cnt + 1;
	end
	assign osc_ready = osc_cnt >= OSC_DLY;
	assign vreg_ready = vreg_cnt >= VREG_DLY;
endmodule

/* test/smc_top_tb.sv */
`timescale 1ns/1ps
module smc_top_tb;
	logic core_clk = 1'b0, rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, ccp_io_key_wr = 1'b0, sleep_instr = 1'b0;
	logic debug_break = 1'b0, run = 1'b0, cpu_instr_done, osc_ready, vreg_ready;
	logic [7:0] irq = 8'h00;
	logic rtc_run_in_standby = 1'b0, ccl_run_in_standby = 1'b1;
	logic [1:0] lut_filter_select = 2'h0;
	logic lut_edge_detect = 1'b0, stby_keep_main_clk = 1'b0, lowfreq_users = 1'b0;
	logic bod_wait_fuse = 1'b1, bod_ready = 1'b1;
	logic cpu_sleeping, cpu_resume, main_clk_en, internal_32k_oscillator_en, vreg_low_power;
	int err_count = 0;
	int n_checks = 0;

	smc_top uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.ccp_io_key_wr, .cpu_instr_done, .sleep_instr, .debug_break, .irq_pin(irq[0]),
		.irq_bod_vlm(irq[1]), .irq_rtc(irq[2]), .irq_pit(irq[3]), .irq_twi_addr(irq[4]),
		.irq_ccl(irq[5]), .irq_usart_sof(irq[6]), .irq_other(irq[7]), .rtc_run_in_standby,
		.ccl_run_in_standby, .lut_filter_select, .lut_edge_detect, .stby_keep_main_clk,
		.lowfreq_users, .osc_ready, .vreg_ready, .bod_wait_fuse, .bod_ready, .cpu_sleeping,
		.cpu_resume, .main_clk_en, .internal_32k_oscillator_en, .vreg_low_power);
	smc_cpu_model cpu (.core_clk, .rst_n, .run, .cpu_sleeping, .main_clk_en, .vreg_low_power,
		.cpu_instr_done, .osc_ready, .vreg_ready);

	always #25 core_clk = ~core_clk;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic tick;
		@(posedge core_clk);
	endtask

	// strobe drops for one cycle so a following request never re-drives it in the same step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		tick;
		reg_wr <= 1'b0;
		tick;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		tick;
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
		tick;
	endtask

	task automatic key;
		ccp_io_key_wr <= 1'b1;
		tick;
		ccp_io_key_wr <= 1'b0;
	endtask

	// e = {sleeping, main clock on, regulator low power} one cycle after the instruction
	task automatic go(input logic [7:0] c, input logic [2:0] e);
		wr(8'h00, c);
		sleep_instr <= 1'b1;
		tick;
		sleep_instr <= 1'b0;
		#1 chk({5'h00, cpu_sleeping, main_clk_en, vreg_low_power}, {5'h00, e});
		tick;
	endtask

	task automatic hold(input logic [7:0] s);
		irq <= s;
		repeat (20) tick;
		#1 chk(8'(cpu_sleeping), 8'h01);
		tick;
		irq <= 8'h00;
		tick;
	endtask

	task automatic wake(input logic [7:0] s, input int lo, input int hi);
		int n;
		n = 0;
		irq <= s;
		while (cpu_resume !== 1'b1 && n < 400)
		begin
			tick;
			#1 n++;
		end
		chk(8'(n >= lo && n <= hi), 8'h01);
		chk(8'(cpu_sleeping), 8'h00);
		tick;
		irq <= 8'h00;
		debug_break <= 1'b0;
		tick;
	endtask

	task automatic t_regs;
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		wr(8'h00, 8'hff);
		rd(8'h00, 8'h0f);
		rd(8'h05, 8'h00);
		wr(8'h01, 8'h11);
		rd(8'h01, 8'h00);
		key;
		run <= 1'b1;
		tick;
		tick;
		run <= 1'b0;
		wr(8'h01, 8'h11);
		rd(8'h01, 8'h11);
		key;
		run <= 1'b1;
		repeat (6) tick;
		run <= 1'b0;
		wr(8'h01, 8'h01);
		rd(8'h01, 8'h11);
		key;
		wr(8'h01, 8'h00);
		rd(8'h01, 8'h00);
	endtask

	task automatic t_sleep;
		go(8'h00, 3'b010);
		go(8'h07, 3'b010);
		go(8'h01, 3'b110);
		wake(8'h80, 9, 9);
		rd(8'h00, 8'h01);
		stby_keep_main_clk <= 1'b1;
		go(8'h03, 3'b111);
		hold(8'h80);
		hold(8'h04);
		rtc_run_in_standby <= 1'b1;
		wake(8'h04, 9, 40);
		stby_keep_main_clk <= 1'b0;
		go(8'h03, 3'b101);
		wake(8'h01, 16, 40);
		go(8'h05, 3'b101);
		#1 chk(8'(internal_32k_oscillator_en), 8'h00);
		tick;
		hold(8'h04);
		lut_filter_select <= 2'h1;
		hold(8'h20);
		lut_filter_select <= 2'h0;
		wake(8'h20, 16, 40);
	endtask

	task automatic t_deep;
		key;
		wr(8'h01, 8'h10);
		lowfreq_users <= 1'b1;
		go(8'h05, 3'b101);
		hold(8'h18);
		wake(8'h01, 16, 40);
		key;
		wr(8'h01, 8'h00);
		go(8'h05, 3'b101);
		wake(8'h08, 16, 40);
		go(8'h05, 3'b101);
		debug_break <= 1'b1;
		wake(8'h00, 16, 40);
		key;
		wr(8'h01, 8'h01);
		go(8'h05, 3'b100);
		wake(8'h01, 16, 40);
		key;
		wr(8'h01, 8'h00);
		bod_ready <= 1'b0;
		go(8'h01, 3'b110);
		hold(8'h80);
		bod_ready <= 1'b1;
		wake(8'h00, 1, 5);
		rd(8'h00, 8'h01);
	endtask

	initial
	begin
		repeat (16) tick;
		#1 chk({4'h0, cpu_sleeping, cpu_resume, main_clk_en, internal_32k_oscillator_en}, 8'h03);
		tick;
		rst_n <= 1'b1;
		t_regs;
		t_sleep;
		t_deep;
		results;
	end

	// the whole run is well under a thousand cycles; this allows twenty thousand
	initial
	begin
		#1000000;
		err_count++;
		results;
	end
endmodule
